// *** shared/nv_ctrl_pkg.sv ***
// Constants and types shared by the nonvolatile memory controller
package nv_ctrl_pkg;
  // Register word indices (byte address is four times the index)
  localparam logic [11:0] IDX_CMD  = 12'hff8;
  localparam logic [11:0] IDX_PAGE = 12'hff9;
  localparam logic [11:0] IDX_FHI  = 12'hffa;
  localparam logic [11:0] IDX_FLO  = 12'hffb;
  // Command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] CMD_PG_ERASE = 8'h95;
  localparam logic [7:0] CMD_MS_ERASE = 8'h63;
  localparam logic [7:0] CMD_PROT_SEL = 8'h5e;
  // Array organisation
  localparam int PAGE_BYTES  = 512;
  localparam int PAGE_SHIFT  = 9;
  localparam int ROW_BYTES   = 64;
  localparam int SECTORS     = 8;
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [15:0] OPT_BYTES = 16'h0002;
  // Reset values
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] BUS_RST  = 32'h0000_0000;
  // Timing: one tick is the kHz setting shifted right, about 31 us
  localparam int TICK_SHIFT = 5;
  // Status codes
  localparam logic [5:0] STS_LOCKED = 6'h00;
  localparam logic [5:0] STS_FIRST  = 6'h01;
  localparam logic [5:0] STS_SECOND = 6'h02;
  localparam logic [5:0] STS_ACTIVE = 6'h03;
  localparam logic [5:0] STS_PROT   = 6'h04;
  localparam logic [5:0] STS_PROG   = 6'h08;
  localparam logic [5:0] STS_PAGE   = 6'h0c;
  localparam logic [5:0] STS_MASS   = 6'h10;

  typedef enum logic [2:0] {
    ST_LOCKED = 3'b000,
    ST_FIRST  = 3'b001,
    ST_SECOND = 3'b011,
    ST_ACTIVE = 3'b010,
    ST_BUSY   = 3'b110
  } nv_state_t;

  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_PAGE, OP_MASS} nv_op_t;
  typedef enum logic [1:0] {AREA_PROG, AREA_OPT, AREA_INFO} nv_area_t;

  typedef struct packed {
    logic        req;
    logic        dbg;
    logic [15:0] addr;
    logic [7:0]  data;
  } prog_req_t;

  typedef struct packed {
    nv_op_t      op;
    nv_area_t    area;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } nv_cmd_t;
endpackage

// *** src/nv_protect_ctrl.sv ***
// Nonvolatile memory controller: unlock sequence, protection, timing
// Contract
// (R1) Pages are 512 bytes, eight 64-byte rows
// (R2) Sector 1024 bytes at largest size, else 512
// (R3) At most 8 sectors, never below page
// (R4) First two bytes are option bits
// (R5) Information area sits at FE00h to FFFFh
// (R6) Timing derives from 16-bit kHz setting
// (R7) Caller keeps clock within 32kHz and 20MHz; the bench runs its clock at 40MHz
// (R8) Read lock hides user code from debugger
// (R9) Write lock blocks user program and erase
// (R10) Write lock clear allows all operations; the code still blocks protected sectors and mass erase for the processor
// (R11) Every reset leaves the controller locked
// (R12) Unlock needs page, 73h then 8Ch
// (R13) Page rewrite must match or relock
// (R14) 95h erases active page if unprotected
// (R15) Wrong command while unlocked relocks controller
// (R16) Mass erase only through debug port
// (R17) Page stays open after byte programming
// (R18) Sector protect bits clear on reset
// (R19) 5Eh maps protect register onto page address
// (R20) User writes only set protect bits
// (R21) Protected sector blocks processor program/erase only
// (R22) Caller writes 00h, 5Eh, protect, 00h
// (R23) Command and status share one address
// (R24) 63h as third command starts mass erase
// (R25) Page erase completion relocks controller
// (R26) Programming only clears bits to zero
// (R27) Stall processor and show busy during ops
//
// Added by the designer: the APB register port.
module nv_protect_ctrl #(
  parameter int MEM_BYTES  = 8192,
  parameter int PROG_TICKS = 2,
  parameter int PAGE_TICKS = 320,
  parameter int MASS_TICKS = 320
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  // APB register port
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [13:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // Register writes come from the debugger
  input  wire logic                  DBG_ACCESS,
  // Option bits, low when programmed
  input  wire logic                  CODE_WRITE_LOCK_OPTION_N,
  input  wire logic                  CODE_READ_LOCK_OPTION_N,
  // Byte program request and current array byte
  input  wire nv_ctrl_pkg::prog_req_t PROG,
  input  wire logic [7:0]            MEM_RDATA,
  // Debugger memory read
  input  wire logic                  DBG_RD_REQ,
  input  wire logic [15:0]           DBG_RD_ADDR,
  output logic      [7:0]            DBG_RDATA,
  output logic                       DBG_RD_DENIED,
  // Array operation and processor stall
  output nv_ctrl_pkg::nv_cmd_t       NV_CMD,
  output logic                       CPU_STALL
);
  import nv_ctrl_pkg::*;

  // (R2) sector size per memory size
  // (R3) one eighth, floored at one page
  localparam int SEC_BYTES = (MEM_BYTES / SECTORS < PAGE_BYTES) ?
                             PAGE_BYTES : MEM_BYTES / SECTORS;
  localparam int SEC_SHIFT = $clog2(SEC_BYTES);
  localparam logic [15:0] T_PROG = 16'(PROG_TICKS - 1);
  localparam logic [15:0] T_PAGE = 16'(PAGE_TICKS - 1);
  localparam logic [15:0] T_MASS = 16'(MASS_TICKS - 1);

  nv_state_t   st_reg, st_next;
  nv_op_t      op_next;
  logic        prot_sel_reg, prot_sel_next;
  logic [7:0]  page_reg, page_next;
  logic [7:0]  prot_reg, prot_next;
  logic [7:0]  fhi_reg, fhi_next;
  logic [7:0]  flo_reg, flo_next;
  logic [15:0] pre_reg, pre_next;
  logic [15:0] tcnt_reg, tcnt_next;
  logic        ready_reg;
  nv_cmd_t     cmd_next;
  logic [5:0]  status;
  logic [31:0] rd_mux;

  // (R23) one index, writes to command and reads to status
  wire [11:0] idx      = PADDR[13:2];
  wire        hit_cmd  = idx == IDX_CMD;
  wire        hit_page = idx == IDX_PAGE;
  wire        hit_fhi  = idx == IDX_FHI;
  wire        hit_flo  = idx == IDX_FLO;
  wire        mapped   = hit_cmd | hit_page | hit_fhi | hit_flo;
  wire        acc_wait = PSEL & PENABLE & ~ready_reg;
  wire        apb_wr   = PSEL & PENABLE & ready_reg & PWRITE & mapped;
  wire [7:0]  wdat     = PWDATA[7:0];
  wire        cmd_wr   = apb_wr & hit_cmd;
  wire        page_wr  = apb_wr & hit_page & ~prot_sel_reg;
  wire        prot_wr  = apb_wr & hit_page & prot_sel_reg;
  wire        idle     = st_reg != ST_BUSY;

  // (R1) page number selects a 512-byte page base
  wire [16:0] page_base = {page_reg, {PAGE_SHIFT{1'b0}}};
  wire [2:0]  page_sec  = 3'(page_base >> SEC_SHIFT);
  wire [2:0]  prog_sec  = 3'(PROG.addr >> SEC_SHIFT);
  wire        prog_hit  = {1'b0, PROG.addr[15:PAGE_SHIFT]} == page_reg;

  // (R9) programmed write lock stops user operations
  // (R10) clear write lock leaves memory open except sectors with protect bits set
  wire        user_ok  = CODE_WRITE_LOCK_OPTION_N;
  // (R21) protect bits apply to processor operations only
  wire        erase_ok = DBG_ACCESS | (user_ok & ~prot_reg[page_sec]);
  wire        prog_ok  = PROG.dbg | (user_ok & prog_hit & ~prot_reg[prog_sec]);
  wire        prog_st  = PROG.dbg ? (st_reg == ST_ACTIVE || st_reg == ST_SECOND)
                                  : (st_reg == ST_ACTIVE);
  wire        prog_go  = PROG.req & prog_st & prog_ok & ~apb_wr;

  // (R5) information area above program memory
  // (R4) lowest two bytes hold option bits
  wire nv_area_t prog_area = (PROG.addr >= INFO_BASE) ? AREA_INFO :
                             (PROG.addr < OPT_BYTES) ? AREA_OPT : AREA_PROG;
  wire           rd_user   = (DBG_RD_ADDR < INFO_BASE);

  // (R6) tick every kHz/32 + 1 cycles so op time scales with the clock
  wire [15:0] pre_lim = {fhi_reg, flo_reg} >> TICK_SHIFT;
  wire        tick    = pre_reg >= pre_lim;
  wire [15:0] op_lim  = (NV_CMD.op == OP_PROG) ? T_PROG :
                        (NV_CMD.op == OP_PAGE) ? T_PAGE : T_MASS;
  wire        done    = ~idle & tick & (tcnt_reg == op_lim);

  // Timer counters only run while an operation is timed
  assign pre_next  = (idle | tick) ? WORD_RST : pre_reg + 16'h0001;
  assign tcnt_next = idle ? WORD_RST : tick ? tcnt_reg + 16'h0001 : tcnt_reg;

  // Status code: busy kinds take priority over unlock stage
  always_comb begin
    case (st_reg)
      ST_FIRST:  status = STS_FIRST;
      ST_SECOND: status = STS_SECOND;
      ST_ACTIVE: status = STS_ACTIVE;
      ST_BUSY:   status = (NV_CMD.op == OP_PROG) ? STS_PROG :
                          (NV_CMD.op == OP_PAGE) ? STS_PAGE : STS_MASS;
      default:   status = prot_sel_reg ? STS_PROT : STS_LOCKED;
    endcase
  end

  // Read data; the command index returns status
  assign rd_mux = hit_cmd  ? {26'h0, status} :
                  hit_page ? {24'h0, prot_sel_reg ? prot_reg : page_reg} :
                  hit_fhi  ? {24'h0, fhi_reg} :
                  hit_flo  ? {24'h0, flo_reg} : BUS_RST;

  // Frequency setting bytes
  assign fhi_next = (apb_wr & hit_fhi) ? wdat : fhi_reg;
  assign flo_next = (apb_wr & hit_flo) ? wdat : flo_reg;

  // (R20) user can only set protect bits; debugger writes freely
  assign prot_next = prot_wr ? (DBG_ACCESS ? wdat : prot_reg | wdat) : prot_reg;

  // Unlock, page select and operation sequencing
  always_comb begin
    st_next       = st_reg;
    op_next       = OP_NONE;
    page_next     = page_reg;
    prot_sel_next = prot_sel_reg;
    if (!idle) begin
      // (R25) erase end relocks; (R17) program end keeps page open
      if (done) begin
        st_next = (NV_CMD.op == OP_PROG) ? ST_ACTIVE : ST_LOCKED;
      end
    end else if (cmd_wr) begin
      // (R19) only 5Eh keeps protect register mapped
      prot_sel_next = wdat == CMD_PROT_SEL;
      case (st_reg)
        // (R12) first unlock code
        ST_LOCKED: st_next = (wdat == CMD_UNLOCK1) ? ST_FIRST : ST_LOCKED;
        // (R12) second unlock code must follow directly
        ST_FIRST:  st_next = (wdat == CMD_UNLOCK2) ? ST_SECOND : ST_LOCKED;
        ST_SECOND, ST_ACTIVE: begin
          // (R15) anything but a valid next command relocks
          st_next = ST_LOCKED;
          // (R14) page erase of an unprotected active page
          if (wdat == CMD_PG_ERASE && erase_ok &&
              (st_reg == ST_ACTIVE || DBG_ACCESS)) begin
            st_next = ST_BUSY;
            op_next = OP_PAGE;
          end
          // (R16) mass erase only from the debugger
          // (R24) third command after unlock
          if (wdat == CMD_MS_ERASE && DBG_ACCESS) begin
            st_next = ST_BUSY;
            op_next = OP_MASS;
          end
        end
        default: st_next = ST_LOCKED;
      endcase
    end else if (page_wr) begin
      case (st_reg)
        ST_LOCKED: page_next = wdat;
        // (R13) rewrite must match; debugger may skip or change it
        ST_SECOND: begin
          if (DBG_ACCESS) begin
            page_next = wdat;
            st_next   = ST_ACTIVE;
          end else begin
            st_next = (wdat == page_reg) ? ST_ACTIVE : ST_LOCKED;
          end
        end
        ST_ACTIVE: page_next = DBG_ACCESS ? wdat : page_reg;
        default:   page_next = page_reg;
      endcase
    end else if (prog_go) begin
      st_next = ST_BUSY;
      op_next = OP_PROG;
    end
  end

  // Array command; held for the whole timed operation
  always_comb begin
    cmd_next = NV_CMD;
    if (done) begin
      cmd_next.op = OP_NONE;
    end else if (op_next == OP_PROG) begin
      cmd_next.op    = OP_PROG;
      cmd_next.area  = prog_area;
      cmd_next.addr  = PROG.addr;
      // (R26) programming can only pull bits low
      cmd_next.wdata = MEM_RDATA & PROG.data;
    end else if (op_next != OP_NONE) begin
      cmd_next.op    = op_next;
      cmd_next.area  = AREA_PROG;
      cmd_next.addr  = (op_next == OP_PAGE) ? page_base[15:0] : WORD_RST;
      cmd_next.wdata = '1;
    end
  end

  // (R11) reset always returns to locked
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg       <= ST_LOCKED;
      prot_sel_reg <= 1'b0;
      page_reg     <= BYTE_RST;
    end else begin
      st_reg       <= st_next;
      prot_sel_reg <= prot_sel_next;
      page_reg     <= page_next;
    end
  end

  // (R18) protect bits lost on every reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prot_reg <= BYTE_RST;
      fhi_reg  <= BYTE_RST;
      flo_reg  <= BYTE_RST;
    end else begin
      prot_reg <= prot_next;
      fhi_reg  <= fhi_next;
      flo_reg  <= flo_next;
    end
  end

  // Operation timer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_reg  <= WORD_RST;
      tcnt_reg <= WORD_RST;
    end else begin
      pre_reg  <= pre_next;
      tcnt_reg <= tcnt_next;
    end
  end

  // (R27) stall mirrors busy so the core waits out the timing
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      NV_CMD    <= '0;
      CPU_STALL <= 1'b0;
    end else begin
      NV_CMD    <= cmd_next;
      CPU_STALL <= st_next == ST_BUSY;
    end
  end

  // APB: one wait state so read data comes from a flop
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ready_reg <= 1'b0;
      PRDATA    <= BUS_RST;
      PSLVERR   <= 1'b0;
    end else begin
      ready_reg <= acc_wait;
      PRDATA    <= (acc_wait & ~PWRITE) ? rd_mux : BUS_RST;
      PSLVERR   <= acc_wait & ~mapped;
    end
  end
  assign PREADY = ready_reg;

  // (R8) debugger reads of user code refused under read lock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DBG_RDATA     <= BYTE_RST;
      DBG_RD_DENIED <= 1'b0;
    end else begin
      DBG_RD_DENIED <= DBG_RD_REQ & rd_user & ~CODE_READ_LOCK_OPTION_N;
      DBG_RDATA     <= (DBG_RD_REQ & (rd_user ? CODE_READ_LOCK_OPTION_N : 1'b1))
                       ? MEM_RDATA : BYTE_RST;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // (R12) wrong first code keeps the lock
  chk_first_code: assert property ( // (R12)
    cmd_wr && st_reg == ST_LOCKED && wdat != CMD_UNLOCK1 |=> st_reg == ST_LOCKED)
    else $error("wrong first code left lock");
  // (R12) second code leads to page rewrite stage
  chk_second_code: assert property ( // (R12)
    cmd_wr && st_reg == ST_FIRST && wdat == CMD_UNLOCK2 |=> st_reg == ST_SECOND)
    else $error("second code not taken");
  // (R13) mismatched page rewrite relocks
  chk_page_match: assert property ( // (R13)
    page_wr && st_reg == ST_SECOND && !DBG_ACCESS && wdat != page_reg
    |=> st_reg == ST_LOCKED)
    else $error("page mismatch did not relock");
  // (R14) protected sector blocks user erase
  chk_erase_prot: assert property ( // (R14)
    cmd_wr && idle && !DBG_ACCESS && prot_reg[page_sec] |=> NV_CMD.op != OP_PAGE)
    else $error("erase of protected sector");
  // (R15) bad command while open relocks
  chk_bad_relock: assert property ( // (R15)
    cmd_wr && st_reg == ST_ACTIVE && wdat != CMD_PG_ERASE && wdat != CMD_MS_ERASE
    |=> st_reg == ST_LOCKED)
    else $error("bad command did not relock");
  // (R16) user code cannot start mass erase
  chk_mass_user: assert property ( // (R16)
    cmd_wr && idle && !DBG_ACCESS |=> NV_CMD.op != OP_MASS)
    else $error("user mass erase started");
  // (R20) user writes never clear protect bits
  chk_prot_sticky: assert property ( // (R20)
    prot_wr && !DBG_ACCESS |=> (prot_reg & $past(prot_reg)) == $past(prot_reg))
    else $error("protect bit cleared by user");
  // (R25) finished page erase relocks
  chk_erase_relock: assert property ( // (R25)
    done && NV_CMD.op == OP_PAGE
    |=> st_reg == ST_LOCKED ##1 (st_reg == ST_LOCKED || st_reg == ST_FIRST))
    else $error("page erase end not locked");
  // (R26) programmed byte only drops bits
  chk_prog_clear: assert property ( // (R26)
    idle ##1 NV_CMD.op == OP_PROG |-> (NV_CMD.wdata & ~$past(MEM_RDATA)) == 8'h00)
    else $error("program raised a bit");
  // (R27) stall tracks busy
  chk_stall_busy: assert property ( // (R27)
    $rose(st_reg == ST_BUSY) |-> CPU_STALL throughout (st_reg == ST_BUSY))
    else $error("busy without stall");
  // (R8) locked reads answer denied next cycle
  chk_read_deny: assert property ( // (R8)
    DBG_RD_REQ && rd_user && !CODE_READ_LOCK_OPTION_N
    |=> DBG_RD_DENIED && DBG_RDATA == 8'h00)
    else $error("locked read not denied");
  // (R27) stall level follows the busy state
  chk_stall_level: assert property ( // (R27)
    CPU_STALL == (st_reg == ST_BUSY))
    else $error("stall differs from busy");
  // (R17) finished byte program keeps page open
  chk_prog_open: assert property ( // (R17)
    done && NV_CMD.op == OP_PROG |=> st_reg == ST_ACTIVE)
    else $error("page closed after program");
  // (R24) debugger 63h after unlock starts mass erase
  chk_mass_dbg: assert property ( // (R24)
    cmd_wr && idle && DBG_ACCESS && wdat == CMD_MS_ERASE &&
    (st_reg == ST_SECOND || st_reg == ST_ACTIVE) |=> NV_CMD.op == OP_MASS)
    else $error("debugger mass erase not started");
endmodule

// *** test/core_bus_model.sv ***
// Processor or debugger model issuing APB register transfers
module core_bus_model
  import nv_ctrl_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [13:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Source of the transfer
  output logic             dbg_access
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    dbg_access = 1'b0;
  end

  // One transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d,
                      input logic dbg, output logic [7:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    dbg_access <= dbg;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale value never looks valid
    pwdata <= ~pwdata;
    dbg_access <= 1'b0;
  endtask

  // page, both codes, then page pg2 unless from the debugger
  task automatic unlock(input logic [7:0] pg1, input logic [7:0] pg2, input logic dbg);
    logic [7:0] rd;
    logic       err;
    xfer(1'b1, IDX_PAGE, pg1, dbg, rd, err);
    xfer(1'b1, IDX_CMD, CMD_UNLOCK1, dbg, rd, err);
    xfer(1'b1, IDX_CMD, CMD_UNLOCK2, dbg, rd, err);
    if (!dbg) xfer(1'b1, IDX_PAGE, pg2, dbg, rd, err);
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the nonvolatile memory controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nv_ctrl_pkg::*;

  // Bench clock in kHz, loaded into the timing registers
  localparam logic [15:0] CLK_KHZ = 16'h9c40;

  logic        CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DBG_ACCESS;
  logic [13:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        WLOCK_N, RLOCK_N, DBG_RD_REQ, DBG_RD_DENIED, CPU_STALL;
  logic [15:0] DBG_RD_ADDR;
  logic [7:0]  MEM_RDATA, DBG_RDATA, v, d;
  prog_req_t   PROG;
  nv_cmd_t     NV_CMD;
  int          errors, cmp_count, cycles, exp_prot;

  // 40 MHz clock and a cycle ceiling against hangs
  initial CLK = 1'b0;
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  core_bus_model u_core_bus_model (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR),
    .dbg_access(DBG_ACCESS));

  // Short timed operations keep the run brief
  nv_protect_ctrl #(.PROG_TICKS(2), .PAGE_TICKS(3), .MASS_TICKS(1)) u_nv_protect_ctrl (
    .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DBG_ACCESS(DBG_ACCESS), .CODE_WRITE_LOCK_OPTION_N(WLOCK_N),
    .CODE_READ_LOCK_OPTION_N(RLOCK_N), .PROG(PROG), .MEM_RDATA(MEM_RDATA),
    .DBG_RD_REQ(DBG_RD_REQ), .DBG_RD_ADDR(DBG_RD_ADDR), .DBG_RDATA(DBG_RDATA),
    .DBG_RD_DENIED(DBG_RD_DENIED), .NV_CMD(NV_CMD), .CPU_STALL(CPU_STALL));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] dt, input logic dbg);
    logic [7:0] rd;
    logic       err;
    u_core_bus_model.xfer(1'b1, idx, dt, dbg, rd, err);
  endtask

  task automatic rd_sts(input logic [5:0] exp);
    logic err;
    u_core_bus_model.xfer(1'b0, IDX_CMD, 8'h00, 1'b0, v, err);
    check(v, {2'b00, exp});
  endtask

  // First array operation seen after a command, then wait out the stall
  task automatic op_check(input nv_op_t e);
    nv_op_t seen;
    int     n;
    seen = OP_NONE;
    for (n = 0; n < 12 && seen == OP_NONE; n++) begin
      @(posedge CLK);
      #1;
      if (NV_CMD.op !== OP_NONE) seen = NV_CMD.op;
    end
    check(seen, e);
    for (n = 0; n < 5000 && CPU_STALL !== 1'b0; n++) @(posedge CLK);
    check(CPU_STALL, 1'b0);
  endtask

  // Byte program request held until the stall answers it
  task automatic prog_byte(input logic [15:0] adr);
    d = 8'($urandom);
    @(posedge CLK);
    MEM_RDATA <= 8'($urandom);
    PROG <= '{req: 1'b1, dbg: 1'b0, addr: adr, data: d};
    for (int n = 0; n < 20 && CPU_STALL !== 1'b1; n++) @(posedge CLK);
    PROG.req <= 1'b0;
    check(CPU_STALL, 1'b1);
    check(NV_CMD.op, OP_PROG);
    check(NV_CMD.addr, adr);
    check(NV_CMD.area, (adr < OPT_BYTES) ? AREA_OPT : AREA_PROG);
    check(NV_CMD.wdata, MEM_RDATA & d);
    for (int n = 0; n < 5000 && CPU_STALL !== 1'b0; n++) @(posedge CLK);
    check(CPU_STALL, 1'b0);
  endtask

  task automatic do_reset();
    @(posedge CLK);
    ARST_N <= 1'b0;
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    exp_prot = 0;
  endtask

  initial begin
    ARST_N = 1'b0;
    WLOCK_N = 1'b1;
    RLOCK_N = 1'b1;
    PROG = '0;
    MEM_RDATA = 8'h00;
    DBG_RD_REQ = 1'b0;
    DBG_RD_ADDR = 16'h0000;
    void'($urandom(32'h960b2dc1));
    do_reset();
    rd_sts(STS_LOCKED);
    // timing registers hold the bench clock in kHz
    wr(IDX_FHI, CLK_KHZ[15:8], 1'b0);
    wr(IDX_FLO, CLK_KHZ[7:0], 1'b0);
    u_core_bus_model.xfer(1'b0, IDX_FLO, 8'h00, 1'b0, v, d[0]);
    check(v, CLK_KHZ[7:0]);
    // reset the sequencer, map, set, clear attempt, unmap
    wr(IDX_CMD, 8'h00, 1'b0);
    wr(IDX_CMD, CMD_PROT_SEL, 1'b0);
    rd_sts(STS_PROT);
    u_core_bus_model.xfer(1'b0, IDX_PAGE, 8'h00, 1'b0, v, d[0]);
    check(v, exp_prot);
    wr(IDX_PAGE, 8'h02, 1'b0);
    exp_prot = exp_prot | 2;
    wr(IDX_PAGE, 8'h00, 1'b0);
    u_core_bus_model.xfer(1'b0, IDX_PAGE, 8'h00, 1'b0, v, d[0]);
    check(v, exp_prot);
    wr(IDX_CMD, 8'h00, 1'b0);
    // Page 2 lies in protected sector 1
    u_core_bus_model.unlock(8'h02, 8'h02, 1'b0);
    rd_sts(STS_ACTIVE);
    wr(IDX_CMD, CMD_PG_ERASE, 1'b0);
    op_check(OP_NONE);
    u_core_bus_model.unlock(8'h00, 8'h01, 1'b0);
    rd_sts(STS_LOCKED);
    // Two bytes on the open page, the second an option byte, then erase it
    u_core_bus_model.unlock(8'h00, 8'h00, 1'b0);
    prog_byte(16'($urandom % PAGE_BYTES));
    rd_sts(STS_ACTIVE);
    prog_byte(OPT_BYTES - 16'h0001);
    rd_sts(STS_ACTIVE);
    wr(IDX_CMD, CMD_PG_ERASE, 1'b0);
    op_check(OP_PAGE);
    rd_sts(STS_LOCKED);
    u_core_bus_model.unlock(8'h00, 8'h00, 1'b0);
    wr(IDX_CMD, 8'($urandom % 8'h5e), 1'b0);
    rd_sts(STS_LOCKED);
    u_core_bus_model.unlock(8'h00, 8'h00, 1'b0);
    wr(IDX_CMD, CMD_MS_ERASE, 1'b0);
    op_check(OP_NONE);
    u_core_bus_model.unlock(8'h00, 8'h00, 1'b1);
    wr(IDX_CMD, CMD_MS_ERASE, 1'b1);
    op_check(OP_MASS);
    rd_sts(STS_LOCKED);
    // Write lock option programmed blocks a user erase
    @(posedge CLK);
    WLOCK_N <= 1'b0;
    u_core_bus_model.unlock(8'h00, 8'h00, 1'b0);
    wr(IDX_CMD, CMD_PG_ERASE, 1'b0);
    op_check(OP_NONE);
    @(posedge CLK);
    WLOCK_N <= 1'b1;
    // Debugger reads with the read lock programmed
    @(posedge CLK);
    RLOCK_N <= 1'b0;
    MEM_RDATA <= 8'($urandom | 1);
    DBG_RD_REQ <= 1'b1;
    DBG_RD_ADDR <= 16'h0100;
    @(posedge CLK);
    DBG_RD_ADDR <= INFO_BASE + 16'h0010;
    #1;
    check(DBG_RD_DENIED, 1'b1);
    check(DBG_RDATA, 8'h00);
    @(posedge CLK);
    DBG_RD_REQ <= 1'b0;
    #1;
    check(DBG_RDATA, MEM_RDATA);
    check(DBG_RD_DENIED, 1'b0);
    // Unmapped index answers with an error
    u_core_bus_model.xfer(1'b0, 12'h010, 8'h00, 1'b0, v, d[0]);
    check(d[0], 1'b1);
    // Mid-run reset drops protection and lock state
    do_reset();
    rd_sts(STS_LOCKED);
    wr(IDX_CMD, CMD_PROT_SEL, 1'b0);
    u_core_bus_model.xfer(1'b0, IDX_PAGE, 8'h00, 1'b0, v, d[0]);
    check(v, exp_prot);
    summarize();
  end
endmodule
